// [design/apc_line_edges.sv]
// apc_line_edges: edge and start/stop detection on the two-wire bus lines.
// assumes scl and sda already synchronous to clock, idle high.
`timescale 1ns/100ps
module apc_line_edges (
	input wire logic clock,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);
	logic scl_q, scl_d, sda_q, sda_d;

	always_comb begin
		scl_d = scl_in;
		sda_d = sda_in;
		scl_rise = ~scl_q & scl_in;
		scl_fall = scl_q & ~scl_in;
		start_det = scl_q & scl_in & sda_q & ~sda_in;
		stop_det = scl_q & scl_in & ~sda_q & sda_in;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end
endmodule

// [design/apc_pkg.sv]
// apc_pkg: register map, field positions, reset values, timing counts and
// the target state type shared by the amplifier power and clock control bank.
// assumes byte-wide registers behind a byte-addressed two-wire target.
package apc_pkg;

	localparam logic [7:0] PWR_OFS = 8'h00;
	localparam logic [7:0] SYS_OFS = 8'h01;
	localparam logic [7:0] REG_COUNT = 8'h02;
	localparam logic [7:0] REG_LAST = 8'h01;

	localparam logic [7:0] PWR_RST = 8'h05;
	localparam logic [7:0] SYS_RST = 8'h30;

	// power_reset_clock_ratio_control fields
	localparam int SRST_BIT = 7;
	localparam int NO_BCLK_BIT = 5;
	localparam int RATIO_LSB = 1;
	localparam int RATIO_MSB = 4;
	localparam int PD_BIT = 0;

	// system_power_edge_clock_control fields
	localparam int HPF_BIT = 7;
	localparam int AMP_LP_BIT = 6;
	localparam int DAC_LP_BIT = 5;
	localparam int APD_BIT = 4;
	localparam int EDGE_LSB = 2;
	localparam int EDGE_MSB = 3;
	localparam int AUTO_MASTER_CLOCK_SELECT_BIT = 1;
	localparam int ASR_BIT = 0;

	// seven-bit target address; device address byte is this value shifted up
	localparam logic [6:0] DEV_ADDR_DEF = 7'h38;

	localparam int ZERO_RUN_LEN = 2048;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_SUB,
		ST_SUB_ACK,
		ST_WDATA,
		ST_WDATA_ACK,
		ST_RDATA,
		ST_RDATA_ACK
	} apc_state_t;

	// ratio code to multiple of the sample rate; zero flags a reserved code
	function automatic logic [9:0] ratio_of(input logic [3:0] code);
		logic [9:0] r;
		r = 10'h000;
		case (code)
			4'h0: r = 10'h040;
			4'h1: r = 10'h080;
			4'h2: r = 10'h100;
			4'h3: r = 10'h180;
			4'h4: r = 10'h200;
			4'h5: r = 10'h300;
			4'h6: r = 10'h064;
			4'h7: r = 10'h0c8;
			4'h8: r = 10'h190;
			default: r = 10'h000;
		endcase
		return r;
	endfunction

	// edge field to speed level: 0 normal, 1 slower, 2 slowest
	function automatic logic [1:0] edge_level(input logic [1:0] code);
		logic [1:0] l;
		l = 2'h0;
		case (code)
			2'h0: l = 2'h0;
			2'h1: l = 2'h1;
			2'h2: l = 2'h1;
			default: l = 2'h2;
		endcase
		return l;
	endfunction

endpackage

// [design/apc_regs.sv]
// apc_regs: two-wire target with the power/reset/clock-ratio and the
// system power/edge/clock control registers, and the control outputs they drive.
// assumes scl/sda sampled synchronously at a rate well above the bus clock;
// sda is open drain, pulled low while sda_oe is high.
//
// Function
// - writing one to the reset bit restores every register and block default
// - no-bit-clock bit selects master clock as bit timing, else the pin
// - ratio field decodes to 64..768, 100, 200, 400 times fs; others reserved
// - master power-down, set at reset, holds all but the bus interface low power
// - filter enable turns on the dc blocking high-pass filter
// - amplifier low-power bit selects return-to-zero class-d modulation
// - converter low-power bit, set at reset, runs the converter at half speed
// - auto power-down enters low power after 2048 consecutive zero samples
// - edge field gives normal, slower or slowest power-stage edges
// - auto master-clock bit uses the detected ratio instead of the field
// - auto sample-rate bit detects rate and ratio, else uses the rate field
// - subaddress advances by one after each written byte and each acknowledged read byte; reads hold at the top
// - nonexistent subaddress is not acknowledged and the target goes idle
`timescale 1ns/100ps
module apc_regs #(
	parameter logic [6:0] DEV_ADDR = apc_pkg::DEV_ADDR_DEF,
	parameter int SAMPLE_W = 24,
	parameter int ZERO_RUN = apc_pkg::ZERO_RUN_LEN
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic mclk_in,
	input wire logic bclk_pin_in,
	input wire logic [3:0] detected_ratio_code,
	input wire logic [1:0] detected_rate_range,
	input wire logic [1:0] sample_rate_range_field,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output logic soft_reset_pulse,
	output logic serial_bit_clock,
	output logic master_power_down_bit,
	output logic low_power_state,
	output logic dc_block_filter_enable,
	output logic amplifier_low_power_bit,
	output logic converter_low_power_bit,
	output logic auto_power_down_enable,
	output logic [1:0] edge_speed,
	output logic auto_master_clock_select,
	output logic auto_sample_rate_bit,
	output logic [9:0] mclk_ratio,
	output logic ratio_reserved,
	output logic [1:0] effective_rate_range
);
	generate
		if (SAMPLE_W < 1 || ZERO_RUN < 1) begin : g_bad
			$error("apc_regs: bad parameters");
		end
	endgenerate

	logic scl_rise, scl_fall, start_det, stop_det;
	logic zero_idle;
	apc_line_edges u_edges (
		.clock(clock),
		.nrst(nrst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);
	apc_pkg::apc_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic [7:0] ptr_q, ptr_d;
	logic oe_q, oe_d;
	logic rw_q, rw_d;
	logic mack_q, mack_d;
	logic wr_en;
	logic [7:0] rd_ptr, rd_byte;
	logic [7:0] pwr_q, pwr_d, sys_q, sys_d;
	logic srst_q, srst_d;
	// pointer past the top reads the highest register
	function automatic logic [7:0] read_byte(input logic [7:0] p, input logic [7:0] pwr, input logic [7:0] sys);
		logic [7:0] v;
		v = sys;
		if (p == apc_pkg::PWR_OFS) begin
			v = pwr;
		end
		return v;
	endfunction
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		rw_d = rw_q;
		mack_d = mack_q;
		wr_en = 1'b0;
		rd_ptr = ptr_q;
		rd_byte = 8'h00;
		if (stop_det) begin
			st_d = apc_pkg::ST_IDLE;
			oe_d = 1'b0;
		end else if (start_det) begin
			st_d = apc_pkg::ST_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else begin
			if (scl_rise) begin
				sh_d = {sh_q[6:0], sda_in};
				cnt_d = 4'(cnt_q + 4'h1);
				if (st_q == apc_pkg::ST_RDATA_ACK) begin
					mack_d = ~sda_in;
				end
			end
			if (scl_fall) begin
				case (st_q)
					apc_pkg::ST_ADDR: begin
						if (cnt_q == apc_pkg::BYTE_BITS) begin
							if (sh_q[7:1] == DEV_ADDR) begin
								st_d = apc_pkg::ST_ADDR_ACK;
								oe_d = 1'b1;
								rw_d = sh_q[0];
							end else begin
								st_d = apc_pkg::ST_IDLE;
							end
						end
					end
					apc_pkg::ST_ADDR_ACK: begin
						cnt_d = 4'h0;
						if (rw_q) begin
							rd_byte = read_byte(ptr_q, pwr_q, sys_q);
							tx_d = rd_byte;
							oe_d = ~rd_byte[7];
							st_d = apc_pkg::ST_RDATA;
						end else begin
							oe_d = 1'b0;
							st_d = apc_pkg::ST_SUB;
						end
					end
					apc_pkg::ST_SUB: begin
						if (cnt_q == apc_pkg::BYTE_BITS) begin
							if (sh_q < apc_pkg::REG_COUNT) begin
								ptr_d = sh_q;
								oe_d = 1'b1;
								st_d = apc_pkg::ST_SUB_ACK;
							end else begin
								st_d = apc_pkg::ST_IDLE;
							end
						end
					end
					apc_pkg::ST_SUB_ACK, apc_pkg::ST_WDATA_ACK: begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						st_d = apc_pkg::ST_WDATA;
					end
					apc_pkg::ST_WDATA: begin
						if (cnt_q == apc_pkg::BYTE_BITS) begin
							if (ptr_q < apc_pkg::REG_COUNT) begin
								wr_en = 1'b1;
								oe_d = 1'b1;
								ptr_d = 8'(ptr_q + 8'h01);
								st_d = apc_pkg::ST_WDATA_ACK;
							end else begin
								st_d = apc_pkg::ST_IDLE;
							end
						end
					end
					apc_pkg::ST_RDATA: begin
						if (cnt_q == apc_pkg::BYTE_BITS) begin
							oe_d = 1'b0;
							st_d = apc_pkg::ST_RDATA_ACK;
						end else begin
							oe_d = ~tx_q[3'(4'h7 - cnt_q)];
						end
					end
					apc_pkg::ST_RDATA_ACK: begin
						if (mack_q) begin
							// advance on read, hold at the top
							if (ptr_q < apc_pkg::REG_LAST) begin
								rd_ptr = 8'(ptr_q + 8'h01);
							end
							ptr_d = rd_ptr;
							rd_byte = read_byte(rd_ptr, pwr_q, sys_q);
							tx_d = rd_byte;
							oe_d = ~rd_byte[7];
							cnt_d = 4'h0;
							st_d = apc_pkg::ST_RDATA;
						end else begin
							oe_d = 1'b0;
							st_d = apc_pkg::ST_IDLE;
						end
					end
					default: begin
						oe_d = 1'b0;
						st_d = apc_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= apc_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			rw_q <= rw_d;
			mack_q <= mack_d;
		end
	end
	always_comb begin
		pwr_d = pwr_q;
		sys_d = sys_q;
		srst_d = 1'b0;
		if (wr_en && ptr_q == apc_pkg::PWR_OFS && sh_q[apc_pkg::SRST_BIT]) begin
			pwr_d = apc_pkg::PWR_RST;
			sys_d = apc_pkg::SYS_RST;
			srst_d = 1'b1;
		end else if (wr_en && ptr_q == apc_pkg::PWR_OFS) begin
			pwr_d = sh_q;
			pwr_d[apc_pkg::SRST_BIT] = 1'b0;
		end else if (wr_en && ptr_q == apc_pkg::SYS_OFS) begin
			sys_d = sh_q;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pwr_q <= apc_pkg::PWR_RST;
			sys_q <= apc_pkg::SYS_RST;
			srst_q <= 1'b0;
		end else begin
			pwr_q <= pwr_d;
			sys_q <= sys_d;
			srst_q <= srst_d;
		end
	end
	apc_zero_run #(
		.SAMPLE_W(SAMPLE_W),
		.RUN_LEN(ZERO_RUN)
	) u_zero (
		.clock(clock),
		.nrst(nrst),
		.enable(sys_q[apc_pkg::APD_BIT]),
		.clear(srst_q),
		.sample_valid(sample_valid),
		.sample_data(sample_data),
		.idle(zero_idle)
	);
	logic bitclk_q, bitclk_d;
	logic lps_q, lps_d;
	logic [1:0] edge_q, edge_d;
	logic [9:0] ratio_q, ratio_d;
	logic rres_q, rres_d;
	logic [1:0] rate_q, rate_d;
	logic [3:0] ratio_code;
	logic auto_ratio;

	always_comb begin
		bitclk_d = pwr_q[apc_pkg::NO_BCLK_BIT] ? mclk_in : bclk_pin_in;
		lps_d = pwr_q[apc_pkg::PD_BIT] | zero_idle;
		edge_d = apc_pkg::edge_level(sys_q[apc_pkg::EDGE_MSB:apc_pkg::EDGE_LSB]);
		auto_ratio = sys_q[apc_pkg::AUTO_MASTER_CLOCK_SELECT_BIT] | sys_q[apc_pkg::ASR_BIT];
		ratio_code = auto_ratio ? detected_ratio_code : pwr_q[apc_pkg::RATIO_MSB:apc_pkg::RATIO_LSB];
		ratio_d = apc_pkg::ratio_of(ratio_code);
		rres_d = (ratio_d == 10'h000);
		rate_d = sys_q[apc_pkg::ASR_BIT] ? detected_rate_range : sample_rate_range_field;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			bitclk_q <= 1'b0;
			lps_q <= 1'b1;
			edge_q <= 2'h0;
			ratio_q <= 10'h000;
			rres_q <= 1'b0;
			rate_q <= 2'h0;
		end else begin
			bitclk_q <= bitclk_d;
			lps_q <= lps_d;
			edge_q <= edge_d;
			ratio_q <= ratio_d;
			rres_q <= rres_d;
			rate_q <= rate_d;
		end
	end
	assign sda_out = 1'b0;
	assign sda_oe = oe_q;
	assign soft_reset_pulse = srst_q;
	assign serial_bit_clock = bitclk_q;
	assign master_power_down_bit = pwr_q[apc_pkg::PD_BIT];
	assign low_power_state = lps_q;
	assign dc_block_filter_enable = sys_q[apc_pkg::HPF_BIT];
	assign amplifier_low_power_bit = sys_q[apc_pkg::AMP_LP_BIT];
	assign converter_low_power_bit = sys_q[apc_pkg::DAC_LP_BIT];
	assign auto_power_down_enable = sys_q[apc_pkg::APD_BIT];
	assign edge_speed = edge_q;
	assign auto_master_clock_select = sys_q[apc_pkg::AUTO_MASTER_CLOCK_SELECT_BIT];
	assign auto_sample_rate_bit = sys_q[apc_pkg::ASR_BIT];
	assign mclk_ratio = ratio_q;
	assign ratio_reserved = rres_q;
	assign effective_rate_range = rate_q;
endmodule

// [design/apc_zero_run.sv]
// apc_zero_run: counts consecutive all-zero input samples and flags idle.
// assumes sample_valid is a one-cycle strobe per received sample.
`timescale 1ns/100ps
module apc_zero_run #(
	parameter int SAMPLE_W = 24,
	parameter int RUN_LEN = apc_pkg::ZERO_RUN_LEN
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic enable,
	input wire logic clear,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	output logic idle
);
	localparam int CW = $clog2(RUN_LEN + 1);
	localparam logic [CW-1:0] RUN_TOP = CW'(RUN_LEN);

	generate
		if (SAMPLE_W < 1 || RUN_LEN < 1) begin : g_bad
			$error("apc_zero_run: bad parameters");
		end
	endgenerate

	logic [CW-1:0] cnt_q, cnt_d;
	logic idle_q, idle_d;

	always_comb begin
		cnt_d = cnt_q;
		if (clear || !enable) begin
			cnt_d = '0;
		end else if (sample_valid) begin
			if (sample_data == '0) begin
				if (cnt_q != RUN_TOP) begin
					cnt_d = CW'(cnt_q + 1'b1);
				end
			end else begin
				cnt_d = '0;
			end
		end
		idle_d = (cnt_d == RUN_TOP);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			idle_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			idle_q <= idle_d;
		end
	end

	assign idle = idle_q;
endmodule

// [verification/apc_host.sv]
// apc_host: two-wire bus master model, drives scl and pulls sda low.
// assumes the bench resolves sda with a pull-up and feeds it back on sda_in.
`timescale 1ns/100ps
module apc_host (
	input wire logic clock,
	input wire logic sda_in,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	// data changes only mid scl low, sampled mid scl high
	task automatic bit_io(input logic b, output logic r);
		tick(3);
		sda_low = ~b;
		tick(3);
		scl = 1'b1;
		tick(3);
		r = sda_in;
		tick(3);
		scl = 1'b0;
	endtask
	task automatic start;
		tick(3);
		sda_low = 1'b0;
		tick(3);
		scl = 1'b1;
		tick(6);
		sda_low = 1'b1;
		tick(6);
		scl = 1'b0;
	endtask
	task automatic stop;
		tick(3);
		sda_low = 1'b1;
		tick(3);
		scl = 1'b1;
		tick(6);
		sda_low = 1'b0;
		tick(6);
	endtask
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(~ack, r);
	endtask
endmodule

// [verification/apc_regs_properties.sv]
// apc_regs_properties: concurrent checks on the control bank ports.
// assumes bound into apc_regs, single clock domain, sda_in already resolved.
`timescale 1ns/100ps
module apc_regs_chk #(
	parameter int SAMPLE_W = 24,
	parameter int ZERO_RUN = 2048
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic mclk_in,
	input wire logic bclk_pin_in,
	input wire logic [3:0] detected_ratio_code,
	input wire logic [1:0] detected_rate_range,
	input wire logic [1:0] sample_rate_range_field,
	input wire logic sample_valid,
	input wire logic [SAMPLE_W-1:0] sample_data,
	input wire logic soft_reset_pulse,
	input wire logic serial_bit_clock,
	input wire logic master_power_down_bit,
	input wire logic low_power_state,
	input wire logic dc_block_filter_enable,
	input wire logic amplifier_low_power_bit,
	input wire logic converter_low_power_bit,
	input wire logic auto_power_down_enable,
	input wire logic auto_master_clock_select,
	input wire logic auto_sample_rate_bit,
	input wire logic [9:0] mclk_ratio,
	input wire logic ratio_reserved,
	input wire logic [1:0] effective_rate_range
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	localparam logic [9:0] RT [16] = '{10'h040, 10'h080, 10'h100, 10'h180, 10'h200, 10'h300, 10'h064, 10'h0c8,
		10'h190, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};
	// consecutive zero samples seen while auto power-down is on
	int zrun_q;
	int zrun_d;
	always_comb begin
		zrun_d = zrun_q;
		if (soft_reset_pulse || !auto_power_down_enable)
			zrun_d = 0;
		else if (sample_valid)
			zrun_d = (sample_data == '0) ? zrun_q + 1 : 0;
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			zrun_q <= 0;
		else
			zrun_q <= zrun_d;
	end
	sequence dflt;
		master_power_down_bit && converter_low_power_bit && auto_power_down_enable && !amplifier_low_power_bit
			&& !dc_block_filter_enable && !auto_master_clock_select && !auto_sample_rate_bit;
	endsequence
	sequence zero_smp;
		sample_valid && sample_data == '0 && auto_power_down_enable;
	endsequence
	sequence run_done;
		zero_smp ##0 zrun_q == ZERO_RUN - 1;
	endsequence
	srst_defaults_a: assert property (soft_reset_pulse |=> dflt)
		else $error("defaults not restored by soft reset");
	srst_pulse_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
		else $error("soft reset pulse too long");
	bclk_mux_a: assert property ($past(nrst) |-> serial_bit_clock == $past(mclk_in)
		|| serial_bit_clock == $past(bclk_pin_in)) else $error("bit clock from no source");
	ratio_flag_a: assert property ($past(nrst) |-> ratio_reserved == (mclk_ratio == 10'h000))
		else $error("reserved flag disagrees with ratio");
	ratio_auto_a: assert property ($past(nrst) && $past(auto_master_clock_select || auto_sample_rate_bit)
		|-> mclk_ratio == RT[$past(detected_ratio_code)]) else $error("detected ratio not used");
	rate_sel_a: assert property ($past(nrst) |-> effective_rate_range == ($past(auto_sample_rate_bit)
		? $past(detected_rate_range) : $past(sample_rate_range_field))) else $error("rate range source wrong");
	pd_low_power_a: assert property ($past(nrst) && $past(master_power_down_bit) |-> low_power_state)
		else $error("power-down without low power");
	zero_run_lp_a: assert property (run_done |-> ##2 low_power_state)
		else $error("low power not entered after zero run");
	ack_scl_low_a: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("sda driven while scl high");
	stop_idle_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:3] !sda_oe)
		else $error("sda held after stop");
endmodule

bind apc_regs apc_regs_chk #(.SAMPLE_W(SAMPLE_W), .ZERO_RUN(ZERO_RUN)) chk (.clock, .nrst, .scl_in, .sda_in,
	.sda_oe, .mclk_in, .bclk_pin_in, .detected_ratio_code, .detected_rate_range, .sample_rate_range_field,
	.sample_valid, .sample_data, .soft_reset_pulse, .serial_bit_clock, .master_power_down_bit, .low_power_state,
	.dc_block_filter_enable, .amplifier_low_power_bit, .converter_low_power_bit, .auto_power_down_enable,
	.auto_master_clock_select, .auto_sample_rate_bit, .mclk_ratio, .ratio_reserved, .effective_rate_range);

// [verification/test_amp_power_clock_control_regs.sv]
// test_amp_power_clock_control_regs: self-checking bench for apc_regs.
// assumes apc_host as bus master and a pull-up on sda; zero run shortened to 4.
`timescale 1ns/100ps
module test_amp_power_clock_control_regs;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic scl_in, sda_low, sda_in, sda_out, sda_oe, serial_bit_clock, soft_reset_pulse, master_power_down_bit;
	logic mclk_in = 1'b0;
	logic bclk_pin_in = 1'b0;
	logic [3:0] detected_ratio_code = 4'h4;
	logic [1:0] detected_rate_range = 2'h1;
	logic [1:0] sample_rate_range_field = 2'h2;
	logic sample_valid = 1'b0;
	logic [23:0] sample_data = 24'h000000;
	logic low_power_state, dc_block_filter_enable, amplifier_low_power_bit, converter_low_power_bit;
	logic auto_power_down_enable, auto_master_clock_select, auto_sample_rate_bit, ratio_reserved;
	logic [1:0] edge_speed, effective_rate_range;
	logic [9:0] mclk_ratio;
	int n_mismatch = 0;
	int checks_done = 0;
	assign sda_in = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	always #5 clock = ~clock;
	always @(negedge clock) begin
		mclk_in <= ~mclk_in;
		if (mclk_in)
			bclk_pin_in <= ~bclk_pin_in;
	end
	apc_regs #(.ZERO_RUN(4)) uut (.clock, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe, .mclk_in, .bclk_pin_in,
		.detected_ratio_code, .detected_rate_range, .sample_rate_range_field, .sample_valid, .sample_data,
		.soft_reset_pulse, .serial_bit_clock, .master_power_down_bit, .low_power_state, .dc_block_filter_enable,
		.amplifier_low_power_bit, .converter_low_power_bit, .auto_power_down_enable, .edge_speed,
		.auto_master_clock_select, .auto_sample_rate_bit, .mclk_ratio, .ratio_reserved, .effective_rate_range);
	apc_host host (.clock, .sda_in, .scl(scl_in), .sda_low);
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] sub, input logic [7:0] d);
		logic a0, a1, a2;
		host.start();
		host.put(8'h70, a0);
		host.put(sub, a1);
		host.put(d, a2);
		host.stop();
		chk(10'({a0, a1, a2}), 10'h007);
	endtask
	task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
		logic a;
		logic [7:0] d;
		host.start();
		host.put(8'h70, a);
		host.put(sub, a);
		host.start();
		host.put(8'h71, a);
		host.get(1'b0, d);
		host.stop();
		chk(10'(d), 10'(exp));
	endtask
	task automatic follow(input logic use_m);
		logic v;
		repeat (4) begin
			@(posedge clock);
			v = use_m ? mclk_in : bclk_pin_in;
			#1 chk(10'(serial_bit_clock), 10'(v));
		end
	endtask
	task automatic smp(input logic [23:0] d);
		sample_valid = 1'b1;
		sample_data = d;
		@(negedge clock);
		sample_valid = 1'b0;
		@(negedge clock);
	endtask
	task automatic t_defaults;
		rd(8'h00, 8'h05);
		rd(8'h01, 8'h30);
		chk(mclk_ratio, 10'h100);
		chk(10'({low_power_state, converter_low_power_bit, auto_power_down_enable}), 10'h007);
		follow(1'b0);
		$display("test defaults done");
	endtask
	task automatic t_burst;
		logic a0, a1, a2, a3, a4;
		logic [7:0] d0, d1;
		host.start();
		host.put(8'h70, a0);
		host.put(8'h00, a1);
		host.put(8'h22, a2);
		host.put(8'hcc, a3);
		host.put(8'h55, a4);
		host.stop();
		chk(10'({a0, a1, a2, a3, a4}), 10'h01e);
		host.start();
		host.put(8'h70, a0);
		host.put(8'h00, a0);
		host.start();
		host.put(8'h71, a0);
		host.get(1'b1, d0);
		host.get(1'b0, d1);
		host.stop();
		chk(10'(d0), 10'h022);
		chk(10'(d1), 10'h0cc);
		chk(10'(dc_block_filter_enable), 10'h001);
		chk(10'(amplifier_low_power_bit), 10'h001);
		chk(10'(converter_low_power_bit), 10'h000);
		chk(10'(low_power_state), 10'h000);
		chk(10'(edge_speed), 10'h002);
		chk(mclk_ratio, 10'h080);
		follow(1'b1);
		$display("test burst done");
	endtask
	task automatic t_codes;
		logic [9:0] tbl [10] = '{10'h040, 10'h080, 10'h100, 10'h180, 10'h200, 10'h300, 10'h064, 10'h0c8,
			10'h190, 10'h000};
		for (int c = 0; c < 10; c++) begin
			wr(8'h00, 8'(2 * c));
			chk(mclk_ratio, tbl[c]);
			chk(10'(ratio_reserved), 10'(c == 9));
		end
		for (int e = 0; e < 4; e++) begin
			wr(8'h01, 8'(4 * e));
			chk(10'(edge_speed), 10'((e + 1) / 2));
		end
		$display("test codes done");
	endtask
	task automatic t_auto;
		wr(8'h00, 8'h04);
		wr(8'h01, 8'h02);
		chk(mclk_ratio, 10'h200);
		chk(10'(effective_rate_range), 10'h002);
		wr(8'h01, 8'h01);
		chk(10'(effective_rate_range), 10'h001);
		chk(mclk_ratio, 10'h200);
		detected_ratio_code = 4'h9;
		host.tick(3);
		chk(10'(ratio_reserved), 10'h001);
		wr(8'h01, 8'h00);
		chk(mclk_ratio, 10'h100);
		$display("test auto done");
	endtask
	task automatic t_refuse;
		logic a0, a1;
		host.start();
		host.put(8'h70, a0);
		host.put(8'h02, a1);
		host.stop();
		chk(10'({a0, a1}), 10'h002);
		host.start();
		host.put(8'h72, a0);
		host.stop();
		chk(10'(a0), 10'h000);
		$display("test refuse done");
	endtask
	task automatic t_soft;
		wr(8'h01, 8'hcf);
		wr(8'h00, 8'ha0);
		rd(8'h00, 8'h05);
		rd(8'h01, 8'h30);
		chk(10'(master_power_down_bit), 10'h001);
		$display("test soft reset done");
	endtask
	task automatic t_zero;
		wr(8'h00, 8'h04);
		for (int i = 0; i < 7; i++)
			smp(i == 3 ? 24'h000100 : 24'h000000);
		host.tick(3);
		chk(10'(low_power_state), 10'h000);
		smp(24'h000000);
		host.tick(1);
		chk(10'(low_power_state), 10'h001);
		$display("test zero run done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		@(negedge clock);
		nrst = 1'b1;
		host.tick(3);
		t_defaults();
		t_burst();
		t_codes();
		t_auto();
		t_refuse();
		t_soft();
		t_zero();
		finish_test();
	end
	// about 30 bus transfers of 1.4 to 6 us each, some 110 us; allow over four times that
	initial begin
		#500000;
		n_mismatch++;
		finish_test();
	end
endmodule
